// File: tws_pkg.sv
`default_nettype none
package tws_pkg;

	////////////////////////////////////////////////////////////////////////
	// timing: one sub-phase lasts a fixed number of core_clk cycles
	localparam int TWS_CLK_HZ = 50_000_000; // core clock rate
	localparam int TWS_SLOTS = 6; // cycles per sub-phase
	localparam logic [2:0] TWS_SLOT_LAST = 3'(TWS_SLOTS - 1); // scale slot
	localparam logic [3:0] TWS_SUBPHASE_LAST = 4'hf; // 16 per interval

	////////////////////////////////////////////////////////////////////////
	// pulse shape selector codes
	localparam logic [3:0] TWS_PS_E1_75 = 4'h0;
	localparam logic [3:0] TWS_PS_E1_120 = 4'h1;
	localparam logic [3:0] TWS_PS_T1_133 = 4'h2; // also j1 and 0 db
	localparam logic [3:0] TWS_PS_T1_266 = 4'h3;
	localparam logic [3:0] TWS_PS_T1_399 = 4'h4;
	localparam logic [3:0] TWS_PS_T1_533 = 4'h5;
	localparam logic [3:0] TWS_PS_T1_655 = 4'h6;
	localparam logic [3:0] TWS_PS_BUILD_75 = 4'h9; // -7.5 db
	localparam logic [3:0] TWS_PS_BUILD_150 = 4'ha; // -15.0 db
	localparam logic [3:0] TWS_PS_BUILD_225 = 4'hb; // -22.5 db
	localparam logic [1:0] TWS_PS_ARB_TOP = 2'h3; // top bits of 11xx

	////////////////////////////////////////////////////////////////////////
	// reference template indices in the rom
	localparam logic [3:0] TWS_TPL_E1_75 = 4'h0;
	localparam logic [3:0] TWS_TPL_E1_120 = 4'h1;
	localparam logic [3:0] TWS_TPL_T1_133 = 4'h2;
	localparam logic [3:0] TWS_TPL_T1_655 = 4'h6;
	localparam logic [3:0] TWS_TPL_J1 = 4'h7;
	localparam logic [3:0] TWS_TPL_BUILD_0 = 4'h8;
	localparam logic [3:0] TWS_TPL_LAST = 4'hb; // twelve templates

	////////////////////////////////////////////////////////////////////////
	// amplitude scaling, gains in units of 1/1024
	localparam logic [5:0] TWS_SCALE_STD_E1 = 6'h21; // 100001
	localparam logic [5:0] TWS_SCALE_STD_T1 = 6'h36; // 110110
	localparam int TWS_STEP_PCT_E1 = 3; // percent per step
	localparam int TWS_STEP_PCT_T1 = 2; // percent per step
	localparam int TWS_GAIN_SHIFT = 10;
	localparam logic [11:0] TWS_GAIN_UNITY = 12'h400;
	localparam logic [11:0] TWS_STEP_E1 =
		12'((TWS_STEP_PCT_E1 * 1024 + 50) / 100);
	localparam logic [11:0] TWS_STEP_T1 =
		12'((TWS_STEP_PCT_T1 * 1024 + 50) / 100);
	localparam logic [11:0] TWS_GAIN_BUILD_75 = 12'h1b0; // 10^(-7.5/20)
	localparam logic [11:0] TWS_GAIN_BUILD_150 = 12'h0b6; // 10^(-15/20)
	localparam logic [11:0] TWS_GAIN_BUILD_225 = 12'h04d; // 10^(-22.5/20)
	localparam int TWS_AMP_MAX = 63; // full scale magnitude

	////////////////////////////////////////////////////////////////////////
	// e1 templates: one edge sample then a flat top, first interval only
	localparam logic [6:0] TWS_E1_75_EDGE = 7'h0c;
	localparam logic [6:0] TWS_E1_75_TOP = 7'h30;
	localparam logic [6:0] TWS_E1_120_EDGE = 7'h0f;
	localparam logic [6:0] TWS_E1_120_TOP = 7'h3c;
	localparam logic [3:0] TWS_E1_EDGE_IDX = 4'h3;
	localparam logic [3:0] TWS_E1_TOP_FIRST = 4'h4;
	localparam logic [3:0] TWS_E1_TOP_LAST = 4'hb;

	////////////////////////////////////////////////////////////////////////
	// t1 templates: first interval and a three-sample tail in the second
	localparam logic [6:0] TWS_T1_HEAD [0:4][0:15] = '{
		'{7'h17, 7'h27, 7'h27, 7'h26, 7'h25, 7'h25, 7'h25, 7'h24,
		  7'h23, 7'h4a, 7'h4a, 7'h49, 7'h47, 7'h45, 7'h44, 7'h43},
		'{7'h1b, 7'h2c, 7'h2b, 7'h2a, 7'h28, 7'h28, 7'h27, 7'h26,
		  7'h25, 7'h50, 7'h4f, 7'h4d, 7'h4a, 7'h48, 7'h46, 7'h44},
		'{7'h1f, 7'h31, 7'h2f, 7'h2c, 7'h2b, 7'h2a, 7'h29, 7'h28,
		  7'h25, 7'h57, 7'h53, 7'h50, 7'h4b, 7'h48, 7'h46, 7'h44},
		'{7'h20, 7'h38, 7'h33, 7'h2f, 7'h2e, 7'h2d, 7'h2c, 7'h2a,
		  7'h28, 7'h58, 7'h58, 7'h53, 7'h4c, 7'h48, 7'h46, 7'h44},
		'{7'h20, 7'h3f, 7'h38, 7'h33, 7'h2f, 7'h2e, 7'h2d, 7'h2c,
		  7'h29, 7'h5f, 7'h5e, 7'h57, 7'h4f, 7'h49, 7'h47, 7'h44}};
	localparam logic [6:0] TWS_T1_TAIL [0:4][0:2] = '{
		'{7'h42, 7'h41, 7'h00},
		'{7'h43, 7'h42, 7'h41},
		'{7'h43, 7'h42, 7'h41},
		'{7'h43, 7'h42, 7'h41},
		'{7'h43, 7'h42, 7'h41}};
	localparam logic [3:0] TWS_TAIL_LEN = 4'h3;

	////////////////////////////////////////////////////////////////////////
	// types
	typedef struct packed {
		logic rd; // 1 read, 0 write
		logic rom; // read back the reference template instead
		logic [1:0] intv; // interval index
		logic [3:0] sidx; // sample index
		logic [6:0] word; // sample word to write
	} tws_access_t;

	typedef struct packed {
		logic active; // a mark was sent
		logic neg; // negative polarity mark
	} tws_symbol_t;

	typedef enum logic [2:0] {
		TWS_ST_IDLE = 3'b001,
		TWS_ST_PEND = 3'b010,
		TWS_ST_CAPT = 3'b100
	} tws_acc_state_t;

endpackage
`default_nettype wire

// File: tws_sample_ram.sv
`timescale 1ns/1ns
`default_nettype none
// 64 x 7 waveform sample store, one port, registered read data
module tws_sample_ram
(
	// clock
	input wire logic clk,
	// port
	input wire logic we,
	input wire logic [5:0] addr,
	input wire logic [6:0] wdata,
	output logic [6:0] rdata
);

	logic [6:0] mem [0:63]; // contents are not reset

	////////////////////////////////////////////////////////////////////////
	// read first: a write returns the old word, read data always registered
	always_ff @(posedge clk)
	begin
		if (we)
			mem[addr] <= wdata;
		rdata <= mem[addr];
	end

endmodule
`default_nettype wire

// File: tws_shaper.sv
`timescale 1ns/1ns
`default_nettype none
module tws_shaper
(
	// clock and reset
	input wire logic core_clk,
	input wire logic srst,
	// configuration
	input wire logic [3:0] pulse_shape_select,
	input wire logic [5:0] amplitude_scaling,
	input wire logic [3:0] reference_template,
	// sample ram access
	input wire logic [1:0] interval_index,
	input wire logic [3:0] sample_index,
	input wire logic [6:0] sample_word,
	input wire logic access_read,
	input wire logic access_rom,
	input wire logic access_trigger,
	output logic access_busy,
	output logic access_done,
	output logic [6:0] read_word,
	// line symbols in, shaped samples out
	input wire logic mark_pos,
	input wire logic mark_neg,
	output logic symbol_take,
	output logic [6:0] line_drive_sample,
	output logic line_drive_strobe
);

	////////////////////////////////////////////////////////////////////////
	// rom lookup of the twelve reference templates
	function automatic logic [6:0] rom_sample(input logic [3:0] tpl,
		input logic [1:0] intv, input logic [3:0] sidx);
		logic [6:0] v;
		logic [2:0] row;
		v = 7'h00;
		row = 3'h0;
		// build-out and j1 references reuse the short cable shape
		if (tpl >= tws_pkg::TWS_TPL_T1_133 && tpl <= tws_pkg::TWS_TPL_T1_655)
			row = 3'(tpl - tws_pkg::TWS_TPL_T1_133);
		if (tpl == tws_pkg::TWS_TPL_E1_75 || tpl == tws_pkg::TWS_TPL_E1_120)
		begin
			// e1 pulses live in the first interval only
			if (intv == 2'h0 && sidx == tws_pkg::TWS_E1_EDGE_IDX)
				v = (tpl == tws_pkg::TWS_TPL_E1_75) ?
					tws_pkg::TWS_E1_75_EDGE : tws_pkg::TWS_E1_120_EDGE;
			else if (intv == 2'h0 && sidx >= tws_pkg::TWS_E1_TOP_FIRST &&
				sidx <= tws_pkg::TWS_E1_TOP_LAST)
				v = (tpl == tws_pkg::TWS_TPL_E1_75) ?
					tws_pkg::TWS_E1_75_TOP : tws_pkg::TWS_E1_120_TOP;
		end
		else if (tpl <= tws_pkg::TWS_TPL_LAST)
		begin
			// t1 family: head interval plus short negative tail
			if (intv == 2'h0)
				v = tws_pkg::TWS_T1_HEAD[row][sidx];
			else if (intv == 2'h1 && sidx < tws_pkg::TWS_TAIL_LEN)
				v = tws_pkg::TWS_T1_TAIL[row][sidx[1:0]];
		end
		return v;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// sub-phase divider: slots 0..3 read, 1..4 sum, last slot scales
	logic [2:0] slot; // position inside one sub-phase
	logic [3:0] subphase; // sub-phase inside the interval
	wire logic slot_last = (slot == tws_pkg::TWS_SLOT_LAST);
	wire logic ui_end = slot_last &&
		(subphase == tws_pkg::TWS_SUBPHASE_LAST);

	// slot counter and sub-phase counter
	always_ff @(posedge core_clk)
	begin
		if (srst)
		begin
			slot <= 3'h0;
			subphase <= 4'h0;
		end
		else
		begin
			slot <= slot_last ? 3'h0 : slot + 3'h1;
			if (slot_last)
				subphase <= subphase + 4'h1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// symbol history: entry k is the pulse launched k intervals ago
	tws_pkg::tws_symbol_t hist [0:3];

	// newest symbol taken at the end of each interval
	always_ff @(posedge core_clk)
	begin
		if (srst)
			hist[0] <= '0;
		else if (ui_end)
			hist[0] <= '{active: mark_pos | mark_neg,
				neg: mark_neg & ~mark_pos};
	end

	// older pulses shift one interval on
	genvar gk;
	generate
		for (gk = 1; gk < 4; gk++)
		begin : g_hist
			always_ff @(posedge core_clk)
			begin
				if (srst)
					hist[gk] <= '0;
				else if (ui_end)
					hist[gk] <= hist[gk - 1];
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// mode decode from the selector
	wire logic sel_arb =
		(pulse_shape_select[3:2] == tws_pkg::TWS_PS_ARB_TOP);
	logic sel_play; // a defined shaping method is chosen
	logic [3:0] play_tpl; // rom template played in preset modes
	logic [11:0] fixed_gain; // gain for preset and build-out modes

	// preset and build-out code table
	always_comb
	begin
		sel_play = 1'b1;
		play_tpl = tws_pkg::TWS_TPL_BUILD_0;
		fixed_gain = tws_pkg::TWS_GAIN_UNITY;
		case (pulse_shape_select)
			tws_pkg::TWS_PS_E1_75,
			tws_pkg::TWS_PS_E1_120:
				play_tpl = pulse_shape_select;
			tws_pkg::TWS_PS_T1_133,
			tws_pkg::TWS_PS_T1_266,
			tws_pkg::TWS_PS_T1_399:
				play_tpl = pulse_shape_select;
			tws_pkg::TWS_PS_T1_533,
			tws_pkg::TWS_PS_T1_655:
				play_tpl = pulse_shape_select;
			tws_pkg::TWS_PS_BUILD_75:
				fixed_gain = tws_pkg::TWS_GAIN_BUILD_75;
			tws_pkg::TWS_PS_BUILD_150:
				fixed_gain = tws_pkg::TWS_GAIN_BUILD_150;
			tws_pkg::TWS_PS_BUILD_225:
				fixed_gain = tws_pkg::TWS_GAIN_BUILD_225;
			default:
				// 0111, 1000 and 11xx play nothing from rom
				sel_play = sel_arb;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// amplitude scaling for the arbitrary waveform
	wire logic ref_e1 = (reference_template == tws_pkg::TWS_TPL_E1_75) ||
		(reference_template == tws_pkg::TWS_TPL_E1_120);
	wire logic [5:0] scale_std = ref_e1 ? tws_pkg::TWS_SCALE_STD_E1 :
		tws_pkg::TWS_SCALE_STD_T1;
	wire logic [11:0] scale_step = ref_e1 ? tws_pkg::TWS_STEP_E1 :
		tws_pkg::TWS_STEP_T1;
	wire logic signed [6:0] scale_diff = signed'({1'b0, amplitude_scaling})
		- signed'({1'b0, scale_std});
	wire logic signed [19:0] gain_wide =
		20'(signed'({1'b0, tws_pkg::TWS_GAIN_UNITY})) +
		20'(scale_diff) * 20'(signed'({1'b0, scale_step}));
	// large downward steps bottom out at silence, never invert
	wire logic signed [12:0] arb_gain = (gain_wide < 0) ? 13'sh0000 :
		gain_wide[12:0];
	wire logic signed [12:0] gain = sel_arb ? arb_gain :
		signed'({1'b0, fixed_gain});

	////////////////////////////////////////////////////////////////////////
	// software access engine
	tws_pkg::tws_acc_state_t state; // access state
	tws_pkg::tws_access_t req; // request latched at the trigger
	wire logic sw_go = (state == tws_pkg::TWS_ST_PEND) && slot_last;

	// ram port: software owns the last slot, playback the first four
	wire logic ram_we = sw_go && !req.rd;
	wire logic [5:0] ram_addr = sw_go ? {req.intv, req.sidx} :
		{slot[1:0], subphase};
	logic [6:0] ram_rdata; // registered read data

	tws_sample_ram u_ram
	(
		.clk(core_clk),
		.we(ram_we),
		.addr(ram_addr),
		.wdata(req.word),
		.rdata(ram_rdata)
	);

	// trigger, wait for the free slot, then finish
	always_ff @(posedge core_clk)
	begin
		if (srst)
		begin
			state <= tws_pkg::TWS_ST_IDLE;
			req <= '0;
			access_done <= 1'b0;
			read_word <= 7'h00;
		end
		else
		begin
			access_done <= 1'b0;
			unique case (state)
				tws_pkg::TWS_ST_IDLE:
					if (access_trigger)
					begin
						// capture indices, word and direction
						req <= '{rd: access_read, rom: access_rom,
							intv: interval_index, sidx: sample_index,
							word: sample_word};
						state <= tws_pkg::TWS_ST_PEND;
					end
				tws_pkg::TWS_ST_PEND:
					if (slot_last)
						state <= tws_pkg::TWS_ST_CAPT;
				tws_pkg::TWS_ST_CAPT:
				begin
					// ram data of the access slot is valid now
					if (req.rd)
						read_word <= req.rom ?
							rom_sample(reference_template, req.intv,
							req.sidx) : ram_rdata;
					access_done <= 1'b1;
					state <= tws_pkg::TWS_ST_IDLE;
				end
			endcase
		end
	end

	// busy reads as the trigger bit still set
	assign access_busy = (state != tws_pkg::TWS_ST_IDLE);

	////////////////////////////////////////////////////////////////////////
	// summing of overlapping pulses
	logic [6:0] rom_q; // rom sample aligned with ram latency
	logic [1:0] term_k; // history entry of the arriving sample
	logic signed [9:0] acc; // sum of up to four terms
	wire logic [6:0] src = sel_arb ? ram_rdata : rom_q;
	wire tws_pkg::tws_symbol_t term_sym = hist[term_k];
	wire logic [9:0] term_mag = {4'h0, src[5:0]};
	wire logic term_on = sel_play && term_sym.active &&
		(slot != 3'h0) && (slot != tws_pkg::TWS_SLOT_LAST);
	wire logic signed [9:0] term = !term_on ? 10'sh000 :
		(src[6] ^ term_sym.neg) ? -signed'(term_mag) :
		signed'(term_mag);

	// rom pipeline and accumulator
	always_ff @(posedge core_clk)
	begin
		if (srst)
		begin
			rom_q <= 7'h00;
			term_k <= 2'h0;
			acc <= 10'sh000;
		end
		else
		begin
			rom_q <= rom_sample(play_tpl, slot[1:0], subphase);
			term_k <= slot[1:0];
			if (slot == 3'h0)
				acc <= 10'sh000;
			else
				acc <= acc + term;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// scale, saturate and return to signed magnitude
	wire logic signed [22:0] prod = 23'(acc) * 23'(gain);
	wire logic signed [12:0] scaled = prod[22:10];
	wire logic signed [12:0] amp_max = 13'(tws_pkg::TWS_AMP_MAX);
	wire logic signed [12:0] clipped = (scaled > amp_max) ? amp_max :
		(scaled < -amp_max) ? -amp_max : scaled;
	wire logic [12:0] clip_abs = clipped[12] ? 13'(-clipped) :
		13'(clipped);
	wire logic [6:0] next_sample = {clipped[12], clip_abs[5:0]};

	// output sample register, one strobe per sub-phase
	always_ff @(posedge core_clk)
	begin
		if (srst)
		begin
			line_drive_sample <= 7'h00;
			line_drive_strobe <= 1'b0;
			symbol_take <= 1'b0;
		end
		else
		begin
			line_drive_strobe <= slot_last;
			symbol_take <= ui_end;
			if (slot_last)
				line_drive_sample <= next_sample;
		end
	end

endmodule
`default_nettype wire

// File: tws_shaper_props.sv
`timescale 1ns/1ns
`default_nettype none
// port-level checks of the shaper
module tws_shaper_chk
(
	// clock and reset
	input wire logic core_clk,
	input wire logic srst,
	// sample access
	input wire logic access_trigger,
	input wire logic access_busy,
	input wire logic access_done,
	input wire logic [6:0] read_word,
	// line side
	input wire logic symbol_take,
	input wire logic [6:0] line_drive_sample,
	input wire logic line_drive_strobe
);
	default clocking @(posedge core_clk);
	endclocking
	default disable iff (srst);
	////////////////////////////////////////
	// an accepted access request
	sequence s_take;
		access_trigger && !access_busy;
	endsequence
	// one sub-phase: five quiet cycles, then the next strobe
	sequence s_subphase;
		!line_drive_strobe [*5] ##1 line_drive_strobe;
	endsequence
	a_take_sets_busy:
		assert property (s_take |=> access_busy)
		else $error("busy did not follow an accepted trigger");
	// done is seen three to eight edges after the take edge
	a_done_in_time:
		assert property (s_take |-> ##[3:8] access_done)
		else $error("access did not finish in time");
	a_done_ends_busy:
		assert property (access_done |-> $past(access_busy) && !access_busy)
		else $error("done without a pending access");
	a_done_one_cycle:
		assert property (access_done |=> !access_done)
		else $error("done longer than one cycle");
	a_read_on_done:
		assert property (!$stable(read_word) && !$past(srst) |-> access_done)
		else $error("read word changed outside done");
	a_strobe_spacing:
		assert property (line_drive_strobe |=> s_subphase)
		else $error("strobe spacing is not six cycles");
	a_sample_held:
		assert property (!line_drive_strobe && !$past(srst)
			|-> $stable(line_drive_sample))
		else $error("sample changed without strobe");
	a_no_minus_zero:
		assert property (line_drive_sample != 7'h40)
		else $error("negative zero on the line");
	a_symbol_period:
		assert property (symbol_take |-> ##96 symbol_take)
		else $error("symbol take not every interval");
endmodule
bind tws_shaper tws_shaper_chk u_chk
(
	.core_clk(core_clk),
	.srst(srst),
	.access_trigger(access_trigger),
	.access_busy(access_busy),
	.access_done(access_done),
	.read_word(read_word),
	.symbol_take(symbol_take),
	.line_drive_sample(line_drive_sample),
	.line_drive_strobe(line_drive_strobe)
);
`default_nettype wire

// File: tws_line_model.sv
`timescale 1ns/1ns
`default_nettype none
// line driver stand-in: sends one mark, records its shaped pulse
module tws_line_model
(
	// clock
	input wire logic core_clk,
	// symbols toward the shaper
	output logic mark_pos,
	output logic mark_neg,
	input wire logic symbol_take,
	// shaped samples back
	input wire logic [6:0] line_drive_sample,
	input wire logic line_drive_strobe
);
	logic [6:0] wave [0:63]; // captured pulse, four intervals
	logic [6:0] count = 7'h40; // strobes recorded, 64 means idle
	logic armed = 1'b0; // mark waiting to be taken
	initial
	begin
		mark_pos = 1'b0;
		mark_neg = 1'b0;
	end
	////////////////////////////////////////
	// mark held until taken, then the next 64 samples are kept
	always @(posedge core_clk)
	begin
		if (symbol_take && armed)
		begin
			armed <= 1'b0;
			mark_pos <= 1'b0;
			mark_neg <= 1'b0;
			count <= 7'h00;
		end
		else if (line_drive_strobe && count < 7'h40)
		begin
			wave[count[5:0]] <= line_drive_sample;
			count <= count + 7'h01;
		end
	end
	// present one mark, avoiding a take already under way
	task automatic send(input logic neg);
		int n;
		@(posedge core_clk);
		#1;
		while (symbol_take === 1'b1)
		begin
			@(posedge core_clk);
			#1;
		end
		armed = 1'b1;
		mark_pos = !neg;
		mark_neg = neg;
		for (n = 0; n < 600 && (armed || count != 7'h40); n++)
			@(posedge core_clk);
		#1;
	endtask
endmodule
`default_nettype wire

// File: tws_shaper_tb.sv
`timescale 1ns/1ns
`default_nettype none
module tws_shaper_tb;
	// clock, reset and configuration
	logic core_clk = 1'b0;
	logic srst = 1'b1;
	logic [3:0] pulse_shape_select = 4'h0;
	logic [5:0] amplitude_scaling = 6'h21;
	logic [3:0] reference_template = 4'h0;
	// sample access and line side
	tws_pkg::tws_access_t acc = '0;
	logic access_trigger = 1'b0;
	logic access_busy, access_done, symbol_take, line_drive_strobe;
	logic mark_pos, mark_neg;
	logic [6:0] read_word, line_drive_sample;
	// bookkeeping and expected shapes
	int fail_count = 0;
	int checks_done = 0;
	int cycles = 0;
	int line_build_out [0:2] = '{432, 182, 77};
	logic [6:0] t1_tab [0:4][0:2] = '{'{7'h17, 7'h4a, 7'h42},
		'{7'h1b, 7'h50, 7'h43}, '{7'h1f, 7'h57, 7'h43},
		'{7'h20, 7'h58, 7'h43}, '{7'h20, 7'h5f, 7'h43}};
	always #10 core_clk = ~core_clk;
	tws_shaper u_dut
	(
		.core_clk(core_clk),
		.srst(srst),
		.pulse_shape_select(pulse_shape_select),
		.amplitude_scaling(amplitude_scaling),
		.reference_template(reference_template),
		.interval_index(acc.intv),
		.sample_index(acc.sidx),
		.sample_word(acc.word),
		.access_read(acc.rd),
		.access_rom(acc.rom),
		.access_trigger(access_trigger),
		.access_busy(access_busy),
		.access_done(access_done),
		.read_word(read_word),
		.mark_pos(mark_pos),
		.mark_neg(mark_neg),
		.symbol_take(symbol_take),
		.line_drive_sample(line_drive_sample),
		.line_drive_strobe(line_drive_strobe)
	);
	tws_line_model u_line
	(
		.core_clk(core_clk),
		.mark_pos(mark_pos),
		.mark_neg(mark_neg),
		.symbol_take(symbol_take),
		.line_drive_sample(line_drive_sample),
		.line_drive_strobe(line_drive_strobe)
	);
	////////////////////////////////////////
	// helpers
	function automatic logic [6:0] pat(input int i);
		return {1'(i % 2), 6'(i % 63 + 1)};
	endfunction
	function automatic logic [6:0] e1(input int i, input logic [6:0] lead,
		input logic [6:0] top);
		if (i == 3)
			return lead;
		return (i >= 4 && i <= 11) ? top : 7'h00;
	endfunction
	task automatic tick();
		@(posedge core_clk);
		#1;
	endtask
	task automatic chk(input logic [6:0] g, input logic [6:0] e);
		checks_done++;
		if (g !== e)
		begin
			fail_count++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	// signed compare within a tolerance
	task automatic near(input logic [6:0] g, input int e, input int tol);
		int v;
		v = g[6] ? -int'(g[5:0]) : int'(g[5:0]);
		checks_done++;
		if ($isunknown(g) || v > e + tol || v < e - tol)
		begin
			fail_count++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	// trigger held a second cycle, which must be refused while busy
	task automatic access(input tws_pkg::tws_access_t a,
		output logic [6:0] r);
		int n;
		acc = a;
		access_trigger = 1'b1;
		tick();
		chk({6'h00, access_busy}, 7'h01);
		acc.word = ~a.word;
		tick();
		access_trigger = 1'b0;
		for (n = 0; n < 20 && access_done !== 1'b1; n++)
			tick();
		chk({5'h00, access_busy, access_done}, 7'h01);
		r = read_word;
		tick();
	endtask
	// a capture that did not complete counts as a mismatch
	task automatic play(input logic [3:0] code, input logic neg);
		pulse_shape_select = code;
		u_line.send(neg);
		chk(u_line.count, 7'h40);
		chk({6'h00, u_line.armed}, 7'h00);
	endtask
	// captured pulse against the ram pattern at a gain in percent
	task automatic expect_arb(input int pct, input logic flip);
		int k;
		int m;
		logic [6:0] w;
		for (k = 0; k < 64; k++)
		begin
			w = pat(k);
			m = int'(w[5:0]) * pct / 100;
			m = m > 63 ? 63 : m;
			near(u_line.wave[k], (w[6] ^ flip) ? -m : m, pct == 100 ? 0 : 1);
		end
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// hang guard
	always @(posedge core_clk)
	begin
		cycles++;
		if (cycles == 30000)
		begin
			fail_count++;
			stop_test();
		end
	end
	////////////////////////////////////////
	// main sequence
	initial
	begin
		int c;
		int k;
		logic [6:0] got;
		logic [6:0] e;
		repeat (6) @(posedge core_clk);
		#1;
		srst = 1'b0;
		chk(line_drive_sample, 7'h00);
		for (k = 0; k < 64; k++)
			access({2'b00, 6'(k), pat(k)}, got);
		for (k = 0; k < 64; k++)
		begin
			access({2'b10, 6'(k), 7'h00}, got);
			chk(got, pat(k));
		end
		for (k = 0; k < 128; k++)
		begin
			reference_template = 4'(k / 64);
			access({2'b11, 6'(k), 7'h00}, got);
			e = k < 64 ? e1(k, 7'h0c, 7'h30) : e1(k - 64, 7'h0f, 7'h3c);
			chk(got, e);
		end
		// rom 2..6 are the cable grades, the rest reuse the short shape
		for (c = 2; c < 12; c++)
		begin
			reference_template = 4'(c);
			access({2'b11, 6'h00, 7'h00}, got);
			e = c < 7 ? t1_tab[c - 2][0] : 7'h17;
			chk(got, e);
		end
		$display("sample access test done");
		amplitude_scaling = 6'h00;
		for (c = 0; c < 2; c++)
		begin
			play(4'(c), 1'(c));
			for (k = 0; k < 64; k++)
			begin
				e = c ? e1(k, 7'h0f, 7'h3c) : e1(k, 7'h0c, 7'h30);
				e[6] = 1'(c != 0 && e != 7'h00);
				chk(u_line.wave[k], e);
			end
		end
		// first head sample, first negative head sample, first tail sample
		for (c = 0; c < 5; c++)
		begin
			play(4'(c + 2), 1'b0);
			for (k = 0; k < 3; k++)
			begin
				e = t1_tab[c][k];
				chk(u_line.wave[k * 9 - k / 2 * 2], e);
			end
		end
		for (c = 0; c < 3; c++)
		begin
			play(4'(c + 9), 1'b0);
			near(u_line.wave[0], 23 * line_build_out[c] / 1024, 1);
			near(u_line.wave[9], -10 * line_build_out[c] / 1024, 1);
		end
		for (c = 7; c < 9; c++)
		begin
			play(4'(c), 1'b0);
			for (k = 0; k < 64; k++)
				chk(u_line.wave[k], 7'h00);
		end
		$display("preset test done");
		reference_template = 4'h0;
		amplitude_scaling = 6'h21;
		for (c = 12; c < 16; c++)
		begin
			play(4'(c), 1'b0);
			expect_arb(100, 1'b0);
		end
		play(4'hc, 1'b1);
		expect_arb(100, 1'b1);
		amplitude_scaling = 6'h26;
		play(4'hd, 1'b0);
		expect_arb(115, 1'b0);
		reference_template = 4'h2;
		amplitude_scaling = 6'h36;
		play(4'he, 1'b0);
		expect_arb(100, 1'b0);
		amplitude_scaling = 6'h34;
		play(4'hf, 1'b0);
		expect_arb(96, 1'b0);
		$display("arbitrary waveform test done");
		stop_test();
	end
endmodule
`default_nettype wire
